// [trb_pkg.sv]
package trb_pkg;

    // ************************************************************
    // Link framing constants
    // ************************************************************
    localparam logic [7:0] BYTE_PAD    = 8'hff;  // Past end of group
    localparam logic [7:0] GCALL_RESET = 8'h06;  // General-call reset byte

    // Command byte codes
    localparam logic [7:0] CMD_RESET  = 8'hff;
    localparam logic [7:0] CMD_TIMER  = 8'hfc;
    localparam logic [7:0] CMD_COMMON = 8'hf8;
    localparam logic [7:0] CMD_SLOT2  = 8'hf9;
    localparam logic [7:0] CMD_SLOT3  = 8'hfa;
    localparam logic [7:0] CMD_SLOT4  = 8'hfb;
    localparam logic [7:0] CMD_SLOT5  = 8'hfd;
    localparam logic [7:0] CMD_CONV   = 8'hfe;
    localparam logic [7:0] CMD_SLEW   = 8'hf7;
    localparam logic [1:0] CMD_CFG_TAG = 2'h2;   // Top two bits of cfg cmd
    localparam int         CMD_TOP     = 7;
    localparam int         CMD_NEXT    = 6;

    // ************************************************************
    // Group layout inside the flat readback vector
    // ************************************************************
    localparam int             IDX_W     = 4;
    localparam int             POS_W     = 5;
    localparam int             REG_BYTES = 26;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hf;
    localparam logic [IDX_W-1:0] LEN_MAIN = 4'hb;
    localparam logic [IDX_W-1:0] LEN_COMMON = 4'h4;
    localparam logic [IDX_W-1:0] LEN_SLOT2 = 4'h3;
    localparam logic [IDX_W-1:0] LEN_PAIR = 4'h2;
    localparam logic [IDX_W-1:0] LEN_NONE = 4'h0;
    localparam logic [POS_W-1:0] BASE_MAIN   = 5'h00;
    localparam logic [POS_W-1:0] BASE_COMMON = 5'h0b;
    localparam logic [POS_W-1:0] BASE_SLOT2  = 5'h0f;
    localparam logic [POS_W-1:0] BASE_SLOT3  = 5'h12;
    localparam logic [POS_W-1:0] BASE_SLOT4  = 5'h14;
    localparam logic [POS_W-1:0] BASE_SLOT5  = 5'h16;
    localparam logic [POS_W-1:0] BASE_CONV   = 5'h18;

    // Link event bit positions
    localparam int EV_CMD   = 0;
    localparam int EV_GCALL = 1;
    localparam int EV_RD    = 2;
    localparam int EV_ACK   = 3;
    localparam int EV_NACK  = 4;
    localparam int EV_N     = 5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        GRP_MAIN   = 3'h0,
        GRP_COMMON = 3'h1,
        GRP_SLOT2  = 3'h2,
        GRP_SLOT3  = 3'h3,
        GRP_SLOT4  = 3'h4,
        GRP_SLOT5  = 3'h5,
        GRP_CONV   = 3'h6,
        GRP_SLEW   = 3'h7
    } trb_grp_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_SEND = 2'h1,
        RD_WAIT = 2'h3
    } trb_rd_e;

    // Byte 0 sits at the top; order follows the read sequences
    typedef struct packed {
        logic [7:0] main_status;
        logic [7:0] main_cfg0;
        logic [7:0] main_cfg1;
        logic [7:0] main_cfg2;
        logic [7:0] main_cfg3;
        logic [7:0] main_cfg4;
        logic [7:0] main_contact_ctrl;
        logic [7:0] timer_hi;
        logic [7:0] timer_lo;
        logic [7:0] capture_hi;
        logic [7:0] capture_lo;
        logic [7:0] aux_status;
        logic [7:0] io_routing_select;
        logic [7:0] aux_contact_ctrl;
        logic [7:0] aux_irq_disable;
        logic [7:0] slot2_cfg0;
        logic [7:0] slot2_cfg1;
        logic [7:0] slot2_cfg2;
        logic [7:0] slot3_cfg0;
        logic [7:0] slot3_cfg2;
        logic [7:0] slot4_cfg0;
        logic [7:0] slot4_cfg2;
        logic [7:0] slot5_cfg0;
        logic [7:0] slot5_cfg2;
        logic [7:0] converter_b_ctrl;
        logic [7:0] regulator_current;
    } trb_regs_s;

    typedef struct packed {
        logic             valid;
        logic [POS_W-1:0] pos;
    } trb_clr_s;

endpackage : trb_pkg

// [trb_sync.sv]
// Toggle event crossing: three stages, change taken once 2nd and 3rd agree
module trb_sync #(
    parameter int N = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] tog_in,
    output logic      [N-1:0] pulse
);
    import trb_pkg::*;

    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] seen;

    // Synchroniser chain
    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= tog_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Last accepted level per event
    always_ff @(posedge clk) begin
        if (rst) begin
            seen <= '0;
        end else begin
            seen <= seen ^ pulse;
        end
    end

    // One pulse per settled change
    assign pulse = ~(s2 ^ s3) & (s3 ^ seen);

endmodule : trb_sync

// [trb_readback.sv]
// Overview of operation
// - Any completed write command with a known code reloads read pointer; unknown codes leave it
// - Reset selects the main-slot group
// - Reading past group end returns FFh
// - Flags clear only after master acknowledge
// - Main group returns eleven bytes in order
// - Common command returns four bytes in order
// - Second-slot command returns three bytes
// - Slots three to five return cfg0, cfg2
// - Fifth-slot command returns two bytes only
// - Converter command returns control, current bytes
// - General call 06h acts as reset
module trb_readback (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              link_clk,
    input  wire logic              lk_rst,
    input  wire logic              lk_cmd_done,
    input  wire logic [7:0]        lk_cmd_byte,
    input  wire logic              lk_gcall_done,
    input  wire logic [7:0]        lk_gcall_byte,
    input  wire logic              lk_rd_start,
    input  wire logic              lk_byte_ack,
    input  wire logic              lk_byte_nack,
    output logic      [7:0]        lk_tx_byte,
    output logic                   lk_tx_valid,
    input  wire trb_pkg::trb_regs_s regs,
    output trb_pkg::trb_clr_s      clr,
    output logic                   dev_reset,
    output trb_pkg::trb_grp_e      rd_group
);
    import trb_pkg::*;

    // ************************************************************
    // Group helpers
    // ************************************************************

    // Group selected by a command byte; unknown codes keep current
    function automatic trb_grp_e cmd_group(logic [7:0] c,
                                           trb_grp_e   cur);
        trb_grp_e g;
        g = cur;
        if (!c[CMD_TOP]) begin
            g = GRP_MAIN;
        end else if (c[CMD_TOP:CMD_NEXT] == CMD_CFG_TAG) begin
            g = GRP_MAIN;
        end else begin
            case (c)
                CMD_RESET:  g = GRP_MAIN;
                CMD_TIMER:  g = GRP_MAIN;
                CMD_COMMON: g = GRP_COMMON;
                CMD_SLOT2:  g = GRP_SLOT2;
                CMD_SLOT3:  g = GRP_SLOT3;
                CMD_SLOT4:  g = GRP_SLOT4;
                CMD_SLOT5:  g = GRP_SLOT5;
                CMD_CONV:   g = GRP_CONV;
                CMD_SLEW:   g = GRP_SLEW;
                default:    g = cur;
            endcase
        end
        return g;
    endfunction : cmd_group

    // Number of readable bytes in a group
    function automatic logic [IDX_W-1:0] grp_len(trb_grp_e g);
        logic [IDX_W-1:0] n;
        n = LEN_NONE;
        case (g)
            GRP_MAIN:   n = LEN_MAIN;
            GRP_COMMON: n = LEN_COMMON;
            GRP_SLOT2:  n = LEN_SLOT2;
            GRP_SLOT3:  n = LEN_PAIR;
            GRP_SLOT4:  n = LEN_PAIR;
            GRP_SLOT5:  n = LEN_PAIR;
            GRP_CONV:   n = LEN_PAIR;
            default:    n = LEN_NONE;
        endcase
        return n;
    endfunction : grp_len

    // First flat byte of a group
    function automatic logic [POS_W-1:0] grp_base(trb_grp_e g);
        logic [POS_W-1:0] b;
        b = BASE_MAIN;
        case (g)
            GRP_COMMON: b = BASE_COMMON;
            GRP_SLOT2:  b = BASE_SLOT2;
            GRP_SLOT3:  b = BASE_SLOT3;
            GRP_SLOT4:  b = BASE_SLOT4;
            GRP_SLOT5:  b = BASE_SLOT5;
            GRP_CONV:   b = BASE_CONV;
            default:    b = BASE_MAIN;
        endcase
        return b;
    endfunction : grp_base

    // Byte at index of group, pad beyond its end
    function automatic logic [7:0] pick(trb_grp_e         g,
                                        logic [IDX_W-1:0] i,
                                        trb_regs_s        r);
        logic [8*REG_BYTES-1:0] flat;
        int                     p;
        logic [7:0]             b;
        flat = r;
        p    = int'(grp_base(g)) + int'(i);
        b    = BYTE_PAD;
        if (i < grp_len(g)) begin
            b = flat[(REG_BYTES-1-p)*8 +: 8];
        end
        return b;
    endfunction : pick

    // ************************************************************
    // Link domain
    // ************************************************************
    logic [EV_N-1:0] lk_tog;
    logic [EV_N-1:0] lk_ev;
    logic [7:0]      lk_cmd_q;
    logic            lk_gcall_ok;
    logic            lk_tx_pulse;
    logic [7:0]      tx_data;

    // General call counts only with the reset byte
    assign lk_gcall_ok = lk_gcall_done &&
                         (lk_gcall_byte == GCALL_RESET);

    assign lk_ev[EV_CMD]   = lk_cmd_done;
    assign lk_ev[EV_GCALL] = lk_gcall_ok;
    assign lk_ev[EV_RD]    = lk_rd_start;
    assign lk_ev[EV_ACK]   = lk_byte_ack;
    assign lk_ev[EV_NACK]  = lk_byte_nack;

    // Event toggles toward the system clock
    always_ff @(posedge link_clk) begin
        if (lk_rst) begin
            lk_tog <= '0;
        end else begin
            lk_tog <= lk_tog ^ lk_ev;
        end
    end

    // Command byte held stable while its event crosses
    always_ff @(posedge link_clk) begin
        if (lk_rst) begin
            lk_cmd_q <= 8'h00;
        end else if (lk_cmd_done) begin
            lk_cmd_q <= lk_cmd_byte;
        end
    end

    // Outgoing byte, valid until the host answers it or starts a new read
    always_ff @(posedge link_clk) begin
        if (lk_rst) begin
            lk_tx_valid <= 1'b0;
            lk_tx_byte  <= BYTE_PAD;
        end else if (lk_tx_pulse) begin
            lk_tx_valid <= 1'b1;
            lk_tx_byte  <= tx_data;
        end else if (lk_byte_ack || lk_byte_nack || lk_rd_start) begin
            lk_tx_valid <= 1'b0;
        end
    end

    // ************************************************************
    // Crossings
    // ************************************************************
    logic [EV_N-1:0] ev;
    logic            tx_tog;

    trb_sync #(.N(EV_N)) u_ev_sync (
        .clk    (sys_clk),
        .rst    (rst),
        .tog_in (lk_tog),
        .pulse  (ev)
    );

    trb_sync #(.N(1)) u_tx_sync (
        .clk    (link_clk),
        .rst    (lk_rst),
        .tog_in (tx_tog),
        .pulse  (lk_tx_pulse)
    );

    // ************************************************************
    // Read pointer
    // ************************************************************
    logic       cmd_ev;
    logic       gc_ev;
    logic       is_reset_cmd;
    trb_grp_e   next_group;

    assign cmd_ev       = ev[EV_CMD];
    assign gc_ev        = ev[EV_GCALL];
    assign is_reset_cmd = (lk_cmd_q == CMD_RESET);
    assign next_group   = cmd_group(lk_cmd_q, rd_group);

    // Pointer follows completed commands and general-call resets only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_group <= GRP_MAIN;
        end else if (gc_ev) begin
            rd_group <= GRP_MAIN;
        end else if (cmd_ev) begin
            rd_group <= next_group;
        end
    end

    // Reset request to the rest of the device
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dev_reset <= 1'b0;
        end else begin
            dev_reset <= gc_ev || (cmd_ev && is_reset_cmd);
        end
    end

    // ************************************************************
    // Read sequencer
    // ************************************************************
    trb_rd_e          rd_state;
    logic [IDX_W-1:0] idx;
    logic             rd_ev;
    logic             ack_ev;
    logic             nack_ev;

    assign rd_ev   = ev[EV_RD];
    assign ack_ev  = ev[EV_ACK];
    assign nack_ev = ev[EV_NACK];

    // Byte walk through the selected group
    always_ff @(posedge sys_clk) begin
        if (rst || gc_ev) begin
            rd_state <= RD_IDLE;
            idx      <= '0;
        end else if (rd_ev) begin
            rd_state <= RD_SEND;
            idx      <= '0;
        end else begin
            case (rd_state)
                RD_SEND: begin
                    rd_state <= RD_WAIT;
                end
                RD_WAIT: begin
                    if (ack_ev) begin
                        rd_state <= RD_SEND;
                        if (idx != IDX_LAST) begin
                            idx <= idx + 1'b1;
                        end
                    end else if (nack_ev) begin
                        rd_state <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= RD_IDLE;
                end
            endcase
        end
    end

    // Load byte and signal the link
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_data <= BYTE_PAD;
            tx_tog  <= 1'b0;
        end else if (rd_state == RD_SEND) begin
            tx_data <= pick(rd_group, idx, regs);
            tx_tog  <= ~tx_tog;
        end
    end

    // Clear request after the byte is acknowledged
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clr <= '0;
        end else begin
            clr.valid <= (rd_state == RD_WAIT) && ack_ev &&
                         (idx < grp_len(rd_group));
            clr.pos   <= grp_base(rd_group) + POS_W'(idx);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_read_open;
        rd_ev && !gc_ev;
    endsequence

    sequence s_first_load;
        (rd_state == RD_SEND && idx == '0) ##1
        (tx_data == pick(rd_group, '0, regs));
    endsequence

    a_ptr_after_reset: assert property (
        @(posedge sys_clk) rst |=> rd_group == GRP_MAIN)
        else $error("pointer not on main group after reset");

    a_cmd_loads_ptr: assert property (
        @(posedge sys_clk) disable iff (rst)
        cmd_ev && !gc_ev |=> rd_group == $past(next_group))
        else $error("command did not load read pointer");

    a_ptr_holds: assert property (
        @(posedge sys_clk) disable iff (rst)
        !cmd_ev && !gc_ev |=> rd_group == $past(rd_group))
        else $error("read pointer moved without command");

    a_read_restart: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_read_open |=> s_first_load)
        else $error("read did not restart at index zero");

    a_index_step: assert property (
        @(posedge sys_clk) disable iff (rst)
        rd_state == RD_WAIT && ack_ev && !rd_ev && !gc_ev &&
        idx != IDX_LAST |=> idx == $past(idx) + 1'b1)
        else $error("index did not advance on acknowledge");

    a_pad_past_end: assert property (
        @(posedge sys_clk) disable iff (rst)
        rd_state == RD_SEND && idx >= grp_len(rd_group)
        |=> tx_data == BYTE_PAD)
        else $error("byte past group end is not FFh");

    a_clear_needs_ack: assert property (
        @(posedge sys_clk) disable iff (rst)
        clr.valid |-> $past(ack_ev) && $past(rd_state) == RD_WAIT)
        else $error("flag clear without acknowledge");

    a_no_clear_nack: assert property (
        @(posedge sys_clk) disable iff (rst)
        nack_ev && !ack_ev |=> !clr.valid)
        else $error("flag clear after not-acknowledge");

    a_gcall_reset: assert property (
        @(posedge sys_clk) disable iff (rst)
        gc_ev |=> rd_group == GRP_MAIN && dev_reset)
        else $error("general call did not reset pointer");

    a_main_timer: assert property (
        @(posedge sys_clk) disable iff (rst)
        rd_state == RD_SEND && rd_group == GRP_MAIN &&
        idx == LEN_MAIN - 4'h4 |=> tx_data == $past(regs.timer_hi))
        else $error("main group byte order wrong");

    a_slot3_second: assert property (
        @(posedge sys_clk) disable iff (rst)
        rd_state == RD_SEND && rd_group == GRP_SLOT3 &&
        idx == LEN_PAIR - 4'h1 |=> tx_data == $past(regs.slot3_cfg2))
        else $error("slot3 second byte wrong");

    a_send_then_wait: assert property (
        @(posedge sys_clk) disable iff (rst)
        rd_state == RD_SEND && !rd_ev && !gc_ev
        |=> rd_state == RD_WAIT [*1] ##1 $stable(tx_data))
        else $error("sender did not wait for host answer");

endmodule : trb_readback

// [trb_host_model.sv]
// Host side of the two-wire link, reduced to the per-event pulses
module trb_host_model (
    input  wire logic       link_clk,
    output logic            lk_cmd_done,
    output logic [7:0]      lk_cmd_byte,
    output logic            lk_gcall_done,
    output logic [7:0]      lk_gcall_byte,
    output logic            lk_rd_start,
    output logic            lk_byte_ack,
    output logic            lk_byte_nack,
    input  wire logic [7:0] lk_tx_byte,
    input  wire logic       lk_tx_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle state at time zero
    initial begin
        lk_cmd_done   = 1'b0;
        lk_gcall_done = 1'b0;
        lk_rd_start   = 1'b0;
        lk_byte_ack   = 1'b0;
        lk_byte_nack  = 1'b0;
        lk_cmd_byte   = 8'h00;
        lk_gcall_byte = 8'h00;
    end

    // One-cycle event: 0 cmd, 1 gcall, 2 read start, 3 ack, 4 nack
    task automatic event_pulse(input int kind, input logic [7:0] b);
        @(posedge link_clk);
        lk_cmd_byte   <= b;
        lk_gcall_byte <= b;
        lk_cmd_done   <= (kind == 0);
        lk_gcall_done <= (kind == 1);
        lk_rd_start   <= (kind == 2);
        lk_byte_ack   <= (kind == 3);
        lk_byte_nack  <= (kind == 4);
        @(posedge link_clk);
        lk_cmd_done   <= 1'b0;
        lk_gcall_done <= 1'b0;
        lk_rd_start   <= 1'b0;
        lk_byte_ack   <= 1'b0;
        lk_byte_nack  <= 1'b0;
        // Byte no longer valid: show a different value, not a stale one
        lk_cmd_byte   <= ~b;
        lk_gcall_byte <= ~b;
        // Spacing so the crossing never merges two events
        repeat (8) @(posedge link_clk);
    endtask : event_pulse

    // Take one byte, then ack it or, for the last, nack it
    task automatic get_byte(input logic last, output logic [7:0] b,
                            output logic ok);
        int n;
        n  = 0;
        ok = 1'b0;
        while (!ok && n < 40) begin
            @(posedge link_clk);
            ok = (lk_tx_valid === 1'b1);
            n++;
        end
        b = lk_tx_byte;
        if (ok) begin
            event_pulse(last ? 4 : 3, 8'h00);
        end
    endtask : get_byte

endmodule : trb_host_model

// [tb_twi_register_readback.sv]
module tb_twi_register_readback;
    timeunit 1ns;
    timeprecision 1ps;
    import trb_pkg::*;

    logic       sys_clk;
    logic       rst;
    logic       link_clk;
    logic       lk_rst;
    logic       lk_cmd_done;
    logic [7:0] lk_cmd_byte;
    logic       lk_gcall_done;
    logic [7:0] lk_gcall_byte;
    logic       lk_rd_start;
    logic       lk_byte_ack;
    logic       lk_byte_nack;
    logic [7:0] lk_tx_byte;
    logic       lk_tx_valid;
    trb_regs_s  regs;
    trb_clr_s   clr;
    logic       dev_reset;
    trb_grp_e   rd_group;
    int         fails;
    int         checks_done;
    int         n_devrst;
    logic [4:0] clr_q[$];
    // Command sequence: each step moves the pointer to a new group
    logic [7:0] cmds  [11] = '{8'hf8, 8'hff, 8'hfa, 8'hfc, 8'hf9, 8'h80,
                               8'hfb, 8'h00, 8'hfd, 8'hfe, 8'hf7};
    trb_grp_e   grps  [11] = '{GRP_COMMON, GRP_MAIN, GRP_SLOT3, GRP_MAIN,
                               GRP_SLOT2, GRP_MAIN, GRP_SLOT4, GRP_MAIN,
                               GRP_SLOT5, GRP_CONV, GRP_SLEW};
    int         bases [11] = '{11, 0, 18, 0, 15, 0, 20, 0, 22, 24, 0};
    int         lens  [11] = '{4, 11, 2, 11, 3, 11, 2, 11, 2, 2, 0};

    trb_readback u_trb_readback (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .link_clk      (link_clk),
        .lk_rst        (lk_rst),
        .lk_cmd_done   (lk_cmd_done),
        .lk_cmd_byte   (lk_cmd_byte),
        .lk_gcall_done (lk_gcall_done),
        .lk_gcall_byte (lk_gcall_byte),
        .lk_rd_start   (lk_rd_start),
        .lk_byte_ack   (lk_byte_ack),
        .lk_byte_nack  (lk_byte_nack),
        .lk_tx_byte    (lk_tx_byte),
        .lk_tx_valid   (lk_tx_valid),
        .regs          (regs),
        .clr           (clr),
        .dev_reset     (dev_reset),
        .rd_group      (rd_group)
    );

    trb_host_model u_host (
        .link_clk      (link_clk),
        .lk_cmd_done   (lk_cmd_done),
        .lk_cmd_byte   (lk_cmd_byte),
        .lk_gcall_done (lk_gcall_done),
        .lk_gcall_byte (lk_gcall_byte),
        .lk_rd_start   (lk_rd_start),
        .lk_byte_ack   (lk_byte_ack),
        .lk_byte_nack  (lk_byte_nack),
        .lk_tx_byte    (lk_tx_byte),
        .lk_tx_valid   (lk_tx_valid)
    );

    // System clock, 4 ns
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Link clock, 12 ns, offset in phase
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #6 link_clk = ~link_clk;
    end

    // Clear pulses and device resets seen in the system domain
    always @(posedge sys_clk) begin
        if (clr.valid === 1'b1) clr_q.push_back(clr.pos);
        if (dev_reset === 1'b1) n_devrst++;
    end

    // ************************************************************
    // Compare and report tasks
    // ************************************************************
    task automatic check_byte(input string nm, input logic [7:0] e,
                              input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check_byte

    task automatic check_cnt(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : check_cnt

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // One read transfer of n bytes; the last one is not acknowledged
    task automatic read_group(input int base, input int len, input int n);
        logic [7:0] b;
        logic       ok;
        int         i;
        clr_q.delete();
        u_host.event_pulse(2, 8'h00);
        for (i = 0; i < n; i++) begin
            u_host.get_byte(i == n - 1, b, ok);
            if (!ok) begin
                fails++;
                $display("BAD tx_valid expected 1 seen 0");
                stop_test();
            end
            check_byte("tx_byte", (i < len) ? 8'(8'h40 + base + i)
                                            : 8'hff, b);
        end
        check_cnt("clr_count", (n - 1 < len) ? n - 1 : len,
                  clr_q.size());
        for (i = 0; i < clr_q.size(); i++)
            check_byte("clr_pos", 8'(base + i), {3'h0, clr_q[i]});
    endtask : read_group

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        fails       = 0;
        checks_done = 0;
        n_devrst    = 0;
        rst         = 1'b1;
        lk_rst      = 1'b1;
        // Byte k of the flat vector holds 40h + k, never FFh
        for (int k = 0; k < 26; k++) regs[207 - 8 * k -: 8] = 8'(8'h40 + k);
        repeat (6) @(posedge sys_clk);
        rst    <= 1'b0;
        lk_rst <= 1'b0;
        repeat (3) @(posedge link_clk);
        check_byte("rd_group", 8'(GRP_MAIN), 8'(rd_group));
        read_group(0, 11, 13);
        $display("test reset_read done");

        read_group(0, 11, 1);
        read_group(0, 11, 3);
        $display("test restart_read done");

        // Host always selects the group before reading it
        for (int c = 0; c < 11; c++) begin
            u_host.event_pulse(0, cmds[c]);
            check_byte("rd_group", 8'(grps[c]), 8'(rd_group));
            read_group(bases[c], lens[c], lens[c] + 2);
        end
        check_cnt("dev_reset", 1, n_devrst);
        $display("test command_table done");

        u_host.event_pulse(0, 8'hc5);
        check_byte("rd_group", 8'(GRP_SLEW), 8'(rd_group));
        read_group(0, 0, 2);
        $display("test unknown_cmd done");

        u_host.event_pulse(1, 8'h05);
        check_byte("rd_group", 8'(GRP_SLEW), 8'(rd_group));
        u_host.event_pulse(1, 8'h06);
        check_byte("rd_group", 8'(GRP_MAIN), 8'(rd_group));
        check_cnt("dev_reset", 2, n_devrst);
        read_group(0, 11, 2);
        $display("test general_call done");

        // Reset in mid-run returns the pointer to the main group
        u_host.event_pulse(0, 8'hf9);
        check_byte("rd_group", 8'(GRP_SLOT2), 8'(rd_group));
        @(posedge sys_clk);
        rst    <= 1'b1;
        lk_rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst    <= 1'b0;
        lk_rst <= 1'b0;
        repeat (3) @(posedge link_clk);
        check_byte("rd_group", 8'(GRP_MAIN), 8'(rd_group));
        read_group(0, 11, 2);
        check_cnt("dev_reset", 2, n_devrst);
        $display("test midrun_reset done");
        stop_test();
    end

endmodule : tb_twi_register_readback
